// *** include/pccd_map.svh ***
// Purpose: Offsets, field values and timing counts of the coil link.
// Assumes: Clock of 4 ns; all counts derived from times below.
// Notes: Included by the package and by both ends.
`ifndef PCCD_MAP_SVH
`define PCCD_MAP_SVH
`define PCCD_FRAME_LEN 8
`define PCCD_FUNC_COIL 8'h05
`define PCCD_BCAST_ADDR 8'h00
`define PCCD_ADDR_BIAS 8'h01
`define PCCD_COIL_SEARCH 16'h049D
`define PCCD_COIL_FINISH 16'h049E
`define PCCD_COIL_START 16'h049F
`define PCCD_DATA_ON 16'hFF00
`define PCCD_DATA_OFF 16'h0000
`define PCCD_CRC_INIT 16'hFFFF
`define PCCD_CRC_POLY 16'hA001
`define PCCD_CLK_NS 4
`define PCCD_SILENT_NS 1000
`define PCCD_SILENT_CYC ((`PCCD_SILENT_NS + `PCCD_CLK_NS - 1) / `PCCD_CLK_NS)
`define PCCD_RESP_WAIT_NS 4000
`define PCCD_RESP_WAIT_CYC (`PCCD_RESP_WAIT_NS / `PCCD_CLK_NS)
`define PCCD_REG_TARGET 8'h00
`define PCCD_REG_COIL 8'h04
`define PCCD_REG_DATA 8'h08
`define PCCD_REG_GO 8'h0C
`define PCCD_REG_STATUS 8'h10
`define PCCD_ST_BUSY 0
`define PCCD_ST_OK 1
`define PCCD_ST_SEEN 2
`define PCCD_ST_DONE 3
`endif

// *** include/pccd_pkg.sv ***
// Purpose: Types and the checksum step shared by both ends.
// Assumes: Map header on the include path.
// Notes: Checksum is the reflected 16-bit form, low byte sent first.
`include "pccd_map.svh"
package pccd_pkg;
  typedef logic [7:0] pccd_byte_t;
  typedef pccd_byte_t [7:0] pccd_frame_t;
  typedef enum logic [1:0] {DEV_RX, DEV_CHECK, DEV_TX} pccd_dev_state_t;
  typedef enum logic [1:0] {H_IDLE, H_LEAD, H_SEND, H_WAIT} pccd_host_state_t;

  function automatic logic [15:0] pccd_crc_step(input logic [15:0] crc,
                                                input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `PCCD_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
endpackage

// *** include/pccd_link_if.sv ***
// Purpose: Byte link between the query master and the coil decoder.
// Assumes: Both ends on one clock; a byte lasts one valid cycle.
// Notes: Silence is a run of cycles with no valid byte.
`timescale 1ns/1ps
`default_nettype none
interface pccd_link_if;
  logic [7:0] m2s_data;
  logic m2s_valid;
  logic [7:0] s2m_data;
  logic s2m_valid;
  modport device (input m2s_data, input m2s_valid,
                  output s2m_data, output s2m_valid);
  modport host (output m2s_data, output m2s_valid,
                input s2m_data, input s2m_valid);
endinterface
`default_nettype wire

// *** design/pccd_device.sv ***
// Purpose: Slave end of the coil link; decodes single-coil writes for
//   search stop, forced finish and program start.
// Assumes: Master keeps the line silent around each query.
// Notes: Replies echo the query; bad or foreign frames get no reply.
`timescale 1ns/1ps
`default_nettype none
`include "pccd_map.svh"

// Notes on behaviour
// - Coil query: function 05, eight bytes
// - Address is axis plus one, own only
// - Address zero is broadcast, always acted on
// - Silent intervals delimit every frame
// - Last two bytes are checked CRC
// - Coil 049D selects stop after search
// - Coil 049E is forced finish control
// - Finish edge 0000 to FF00 ends program
// - Held finish coil rejects program start
// - Coil 049F is program start control
// - Only start rising edge launches program
// - Launched program is commanded program number
// - Master writes 0000 then FF00 for edge
// - Good own-address write answered with identical echo
// - Invalid data gets no reply
module pccd_device (
  input wire logic hclk,
  input wire logic hresetn,
  pccd_link_if.device link,
  input wire logic [3:0] axis_id,
  input wire logic [15:0] program_number_command,
  output logic search_stop_select,
  output logic forced_program_finish,
  output logic forced_finish_pulse,
  output logic program_start_trigger,
  output logic start_rejected,
  output logic [15:0] launched_program,
  output logic frame_accepted
);

  typedef struct packed {
    pccd_pkg::pccd_dev_state_t state;
    pccd_pkg::pccd_frame_t frame;
    logic [3:0] count;
    logic [15:0] crc;
    logic [8:0] gap;
    logic seen;
    logic [2:0] tx_idx;
    logic tx_valid;
    logic [7:0] tx_data;
    logic search_stop;
    logic forced_finish;
    logic start_coil;
    logic finish_pulse;
    logic start_pulse;
    logic reject_pulse;
    logic accepted;
    logic [15:0] launched;
    logic [3:0] axis_meta;
    logic [3:0] axis_sync;
  } pccd_dev_regs_t;

  pccd_dev_regs_t st_reg;
  pccd_dev_regs_t st_next;

  logic [7:0] own_addr;
  logic [15:0] coil_addr;
  logic [15:0] coil_data;
  logic is_bcast;
  logic addr_match;
  logic frame_sound;
  logic data_on;
  logic data_ok;
  logic coil_known;
  logic [15:0] crc_base;

  // Axis strap is read only after its second flop
  assign own_addr = {4'h0, st_reg.axis_sync} + `PCCD_ADDR_BIAS;
  assign coil_addr = {st_reg.frame[2], st_reg.frame[3]};
  assign coil_data = {st_reg.frame[4], st_reg.frame[5]};
  assign is_bcast = st_reg.frame[0] == `PCCD_BCAST_ADDR;
  assign addr_match = is_bcast || (st_reg.frame[0] == own_addr);
  assign frame_sound = (st_reg.count == 4'(`PCCD_FRAME_LEN)) &&
                       (st_reg.crc == 16'h0000) &&
                       (st_reg.frame[1] == `PCCD_FUNC_COIL);
  assign data_on = coil_data == `PCCD_DATA_ON;
  assign data_ok = data_on || (coil_data == `PCCD_DATA_OFF);
  assign coil_known = (coil_addr == `PCCD_COIL_SEARCH) ||
                      (coil_addr == `PCCD_COIL_FINISH) ||
                      (coil_addr == `PCCD_COIL_START);
  // First byte of a frame starts from the initial checksum
  assign crc_base = (st_reg.count == 4'h0) ? `PCCD_CRC_INIT : st_reg.crc;

  always_comb begin
    st_next = st_reg;
    st_next.finish_pulse = 1'b0;
    st_next.start_pulse = 1'b0;
    st_next.reject_pulse = 1'b0;
    st_next.accepted = 1'b0;
    st_next.tx_valid = 1'b0;
    st_next.axis_meta = axis_id;
    st_next.axis_sync = st_reg.axis_meta;
    case (st_reg.state)
      pccd_pkg::DEV_RX: begin
        if (link.m2s_valid) begin
          st_next.seen = 1'b1;
          st_next.gap = 9'h000;
          st_next.crc = pccd_pkg::pccd_crc_step(crc_base, link.m2s_data);
          if (st_reg.count < 4'(`PCCD_FRAME_LEN)) begin
            st_next.frame[st_reg.count[2:0]] = link.m2s_data;
          end
          // Overlong frames saturate one past the length
          if (st_reg.count <= 4'(`PCCD_FRAME_LEN)) begin
            st_next.count = st_reg.count + 4'h1;
          end
        end else if (st_reg.seen) begin
          if (st_reg.gap == 9'(`PCCD_SILENT_CYC - 1)) begin
            st_next.state = pccd_pkg::DEV_CHECK;
          end else begin
            st_next.gap = st_reg.gap + 9'h001;
          end
        end
      end
      pccd_pkg::DEV_CHECK: begin
        st_next.state = pccd_pkg::DEV_RX;
        st_next.seen = 1'b0;
        st_next.count = 4'h0;
        st_next.gap = 9'h000;
        if (frame_sound && addr_match && coil_known && data_ok) begin
          st_next.accepted = 1'b1;
          case (coil_addr)
            `PCCD_COIL_SEARCH: begin
              st_next.search_stop = data_on;
            end
            `PCCD_COIL_FINISH: begin
              if (data_on && !st_reg.forced_finish) begin
                st_next.finish_pulse = 1'b1;
              end
              st_next.forced_finish = data_on;
            end
            `PCCD_COIL_START: begin
              if (data_on && !st_reg.start_coil) begin
                if (st_reg.forced_finish) begin
                  st_next.reject_pulse = 1'b1;
                end else begin
                  st_next.start_pulse = 1'b1;
                  st_next.launched = program_number_command;
                end
              end
              st_next.start_coil = data_on;
            end
            default: begin
              st_next.accepted = 1'b0;
            end
          endcase
          if (!is_bcast) begin
            st_next.state = pccd_pkg::DEV_TX;
            st_next.tx_idx = 3'h0;
          end
        end
      end
      pccd_pkg::DEV_TX: begin
        st_next.tx_valid = 1'b1;
        st_next.tx_data = st_reg.frame[st_reg.tx_idx];
        st_next.tx_idx = st_reg.tx_idx + 3'h1;
        if (st_reg.tx_idx == 3'(`PCCD_FRAME_LEN - 1)) begin
          st_next.state = pccd_pkg::DEV_RX;
        end
      end
      default: begin
        st_next.state = pccd_pkg::DEV_RX;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.s2m_data = st_reg.tx_data;
  assign link.s2m_valid = st_reg.tx_valid;
  assign search_stop_select = st_reg.search_stop;
  assign forced_program_finish = st_reg.forced_finish;
  assign forced_finish_pulse = st_reg.finish_pulse;
  assign program_start_trigger = st_reg.start_pulse;
  assign start_rejected = st_reg.reject_pulse;
  assign launched_program = st_reg.launched;
  assign frame_accepted = st_reg.accepted;

endmodule
`default_nettype wire

// *** design/pccd_host.sv ***
// Purpose: Query master of the coil link, driven over AHB-Lite.
// Assumes: Zero-wait slave; software sequences 0000 then FF00 writes.
// Notes: Status shows whether the echo matched the sent query.
`timescale 1ns/1ps
`default_nettype none
`include "pccd_map.svh"

module pccd_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  pccd_link_if.host link
);

  typedef struct packed {
    pccd_pkg::pccd_host_state_t state;
    logic [7:0] target;
    logic [15:0] coil;
    logic [15:0] data;
    pccd_pkg::pccd_frame_t tx;
    pccd_pkg::pccd_frame_t rx;
    logic [3:0] rx_count;
    logic [2:0] idx;
    logic [11:0] gap;
    logic ok;
    logic seen;
    logic done;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic ready;
    logic [7:0] m2s_data;
    logic m2s_valid;
  } pccd_host_regs_t;

  pccd_host_regs_t st_reg;
  pccd_host_regs_t st_next;
  pccd_pkg::pccd_frame_t build;
  logic [15:0] crc;
  logic take;
  logic mapped;

  assign take = hsel && hready && htrans[1];
  assign mapped = haddr[31:8] == 24'h000000;

  always_comb begin
    build = '0;
    build[0] = st_reg.target;
    build[1] = `PCCD_FUNC_COIL;
    build[2] = st_reg.coil[15:8];
    build[3] = st_reg.coil[7:0];
    build[4] = st_reg.data[15:8];
    build[5] = st_reg.data[7:0];
    crc = `PCCD_CRC_INIT;
    for (int i = 0; i < 6; i++) begin
      crc = pccd_pkg::pccd_crc_step(crc, build[i]);
    end
    build[6] = crc[7:0];
    build[7] = crc[15:8];
  end

  always_comb begin
    st_next = st_reg;
    st_next.ready = 1'b1;
    st_next.m2s_valid = 1'b0;
    st_next.wr_pend = take && hwrite && mapped;
    st_next.wr_addr = haddr[7:0];
    if (take && !hwrite) begin
      st_next.rdata = 32'h00000000;
      if (mapped) begin
        case (haddr[7:0])
          `PCCD_REG_TARGET: st_next.rdata = {24'h000000, st_reg.target};
          `PCCD_REG_COIL: st_next.rdata = {16'h0000, st_reg.coil};
          `PCCD_REG_DATA: st_next.rdata = {16'h0000, st_reg.data};
          `PCCD_REG_STATUS: begin
            st_next.rdata[`PCCD_ST_BUSY] = st_reg.state != pccd_pkg::H_IDLE;
            st_next.rdata[`PCCD_ST_OK] = st_reg.ok;
            st_next.rdata[`PCCD_ST_SEEN] = st_reg.seen;
            st_next.rdata[`PCCD_ST_DONE] = st_reg.done;
          end
          default: st_next.rdata = 32'h00000000;
        endcase
      end
    end
    if (st_reg.wr_pend) begin
      case (st_reg.wr_addr)
        `PCCD_REG_TARGET: st_next.target = hwdata[7:0];
        `PCCD_REG_COIL: st_next.coil = hwdata[15:0];
        `PCCD_REG_DATA: st_next.data = hwdata[15:0];
        `PCCD_REG_GO: begin
          if (hwdata[0] && st_reg.state == pccd_pkg::H_IDLE) begin
            st_next.tx = build;
            st_next.state = pccd_pkg::H_LEAD;
            st_next.gap = 12'h000;
            st_next.ok = 1'b0;
            st_next.seen = 1'b0;
            st_next.done = 1'b0;
          end
        end
        default: st_next.gap = st_next.gap;
      endcase
    end
    case (st_reg.state)
      pccd_pkg::H_IDLE: st_next.idx = 3'h0;
      pccd_pkg::H_LEAD: begin
        if (st_reg.gap == 12'(`PCCD_SILENT_CYC - 1)) begin
          st_next.state = pccd_pkg::H_SEND;
          st_next.idx = 3'h0;
        end else begin
          st_next.gap = st_reg.gap + 12'h001;
        end
      end
      pccd_pkg::H_SEND: begin
        st_next.m2s_valid = 1'b1;
        st_next.m2s_data = st_reg.tx[st_reg.idx];
        st_next.idx = st_reg.idx + 3'h1;
        if (st_reg.idx == 3'(`PCCD_FRAME_LEN - 1)) begin
          st_next.state = pccd_pkg::H_WAIT;
          st_next.gap = 12'h000;
          st_next.rx_count = 4'h0;
        end
      end
      pccd_pkg::H_WAIT: begin
        if (link.s2m_valid) begin
          st_next.gap = 12'h000;
          if (st_reg.rx_count < 4'(`PCCD_FRAME_LEN)) begin
            st_next.rx[st_reg.rx_count[2:0]] = link.s2m_data;
          end
          if (st_reg.rx_count <= 4'(`PCCD_FRAME_LEN)) begin
            st_next.rx_count = st_reg.rx_count + 4'h1;
          end
        end else if ((st_reg.rx_count != 4'h0 &&
                      st_reg.gap == 12'(`PCCD_SILENT_CYC - 1)) ||
                     st_reg.gap == 12'(`PCCD_RESP_WAIT_CYC - 1)) begin
          st_next.ok = (st_reg.rx_count == 4'(`PCCD_FRAME_LEN)) &&
                       (st_reg.rx == st_reg.tx);
          st_next.seen = st_reg.rx_count != 4'h0;
          st_next.done = 1'b1;
          st_next.state = pccd_pkg::H_IDLE;
        end else begin
          st_next.gap = st_reg.gap + 12'h001;
        end
      end
      default: st_next.state = pccd_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hreadyout = st_reg.ready;
  assign hresp = 1'b0;
  assign hrdata = st_reg.rdata;
  assign link.m2s_data = st_reg.m2s_data;
  assign link.m2s_valid = st_reg.m2s_valid;

endmodule
`default_nettype wire

// *** testbench/pccd_link_assertions.sv ***
// Purpose: Wire checks on the coil link between host and decoder.
// Assumes: One clock; the bytes of a frame come back to back.
// Notes: idle counts cycles with both valids low.
`timescale 1ns/1ps
`default_nettype none
`include "pccd_map.svh"
module pccd_link_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] m2s_data,
  input wire logic m2s_valid,
  input wire logic [7:0] s2m_data,
  input wire logic s2m_valid
);
  localparam int SIL = `PCCD_SILENT_CYC;
  logic [3:0] m_cnt, s_cnt, mi, si;
  logic [9:0] idle;
  logic [7:0] q [8];
  // Byte index inside the current burst
  assign mi = (idle != 10'h0) ? 4'h0 : m_cnt;
  assign si = (idle != 10'h0) ? 4'h0 : s_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      m_cnt <= 4'h0;
      s_cnt <= 4'h0;
      idle <= 10'h0;
      q <= '{default: 8'h00};
    end else begin
      if (m2s_valid) m_cnt <= mi + 4'h1;
      if (m2s_valid && !mi[3]) q[mi[2:0]] <= m2s_data;
      if (s2m_valid) s_cnt <= si + 4'h1;
      if (m2s_valid || s2m_valid) idle <= 10'h0;
      else if (idle != 10'h3FF) idle <= idle + 10'h1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_m_len; $fell(m2s_valid) |-> m_cnt == 4'h8; endproperty
  a_m_len: assert property (p_m_len)
    else $error("query not eight bytes");
  property p_m_func;
    m2s_valid && mi == 4'h1 |-> m2s_data == `PCCD_FUNC_COIL;
  endproperty
  a_m_func: assert property (p_m_func)
    else $error("query function byte wrong");
  property p_m_gap; $rose(m2s_valid) |-> idle >= SIL - 1; endproperty
  a_m_gap: assert property (p_m_gap)
    else $error("query without leading silence");
  property p_s_gap;
    $rose(s2m_valid) |-> idle >= SIL - 1 && idle <= SIL + 3;
  endproperty
  a_s_gap: assert property (p_s_gap)
    else $error("reply not one silence after query");
  property p_s_len; $fell(s2m_valid) |-> s_cnt == 4'h8; endproperty
  a_s_len: assert property (p_s_len)
    else $error("reply not eight bytes");
  property p_echo; s2m_valid && !si[3] |-> s2m_data == q[si[2:0]];
  endproperty
  a_echo: assert property (p_echo)
    else $error("reply byte differs from query");
  property p_bcast; s2m_valid |-> q[0] != `PCCD_BCAST_ADDR; endproperty
  a_bcast: assert property (p_bcast)
    else $error("reply to broadcast");
  property p_duplex; s2m_valid |-> !m2s_valid; endproperty
  a_duplex: assert property (p_duplex)
    else $error("both ends drive at once");
endmodule
`default_nettype wire

// *** testbench/tb_press_coil_command_decoder.sv ***
// Purpose: Bench for host and decoder joined by the link.
// Assumes: Host registers at the offsets of the map header.
// Notes: A second decoder is fed bad frames by the bench.
`timescale 1ns/1ps
`default_nettype none
`include "pccd_map.svh"
module tb_press_coil_command_decoder;
  logic hclk, hresetn, hsel, hwrite, hready, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [3:0] axis_id;
  logic [15:0] pnum, lprog;
  logic ss, fin, fin_p, trig, rej, acc, fin2, acc2;
  int fail_count = 0;
  int n_tests = 0;
  int nf, nt, nr, na, na2, ns2, m_ss, m_fin, m_st, m_lp;
  logic [7:0] wq [$];
  localparam logic [47:0] DIR [9] = '{48'h049E_0000_AD14,
    48'h049E_FF00_ECE4, 48'h049F_0000_FCD4, 48'h049F_FF00_BD24,
    48'h049E_0000_AD14, 48'h049F_0000_FCD4, 48'h049F_FF00_BD24,
    48'h049F_FF00_BD24, 48'h049D_FF00_1CE4};
  pccd_link_if link();
  pccd_link_if link2();
  pccd_host u_pccd_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .link(link.host));
  pccd_device u_pccd_device (.hclk(hclk), .hresetn(hresetn),
    .link(link.device), .axis_id(axis_id), .program_number_command(pnum),
    .search_stop_select(ss), .forced_program_finish(fin),
    .forced_finish_pulse(fin_p), .program_start_trigger(trig),
    .start_rejected(rej), .launched_program(lprog), .frame_accepted(acc));
  pccd_device u_pccd_device_2 (.hclk(hclk), .hresetn(hresetn),
    .link(link2.device), .axis_id(4'h0), .program_number_command(pnum),
    .search_stop_select(), .forced_program_finish(fin2),
    .forced_finish_pulse(), .program_start_trigger(), .start_rejected(),
    .launched_program(), .frame_accepted(acc2));
  pccd_link_assertions u_pccd_link_assertions (.hclk(hclk),
    .hresetn(hresetn), .m2s_data(link.m2s_data),
    .m2s_valid(link.m2s_valid), .s2m_data(link.s2m_data),
    .s2m_valid(link.s2m_valid));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Pulse counters and capture of the query bytes on the wire
  always @(posedge hclk) begin
    nf += (fin_p === 1'b1);
    nt += (trig === 1'b1);
    nr += (rej === 1'b1);
    na += (acc === 1'b1);
    na2 += (acc2 === 1'b1);
    ns2 += (link2.s2m_valid === 1'b1);
    if (link.m2s_valid === 1'b1) wq.push_back(link.m2s_data);
  end
  task automatic chk_b(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chk_w(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic query(input logic [7:0] t, input logic [15:0] c, d);
    logic [31:0] st;
    int f0, t0, r0, a0, k, ok, on, ef, et, er;
    f0 = nf;
    t0 = nt;
    r0 = nr;
    a0 = na;
    wq.delete();
    pnum <= 16'($urandom);
    ahb(1'b1, `PCCD_REG_TARGET, {24'h0, t}, st);
    ahb(1'b1, `PCCD_REG_COIL, {16'h0, c}, st);
    ahb(1'b1, `PCCD_REG_DATA, {16'h0, d}, st);
    ahb(1'b1, `PCCD_REG_GO, 32'h1, st);
    k = 0;
    do begin
      ahb(1'b0, `PCCD_REG_STATUS, 32'h0, st);
      k++;
    end while (st[`PCCD_ST_DONE] !== 1'b1 && k < 1000);
    on = (d == `PCCD_DATA_ON);
    ok = (t == {4'h0, axis_id} + `PCCD_ADDR_BIAS || t == `PCCD_BCAST_ADDR)
      && c >= `PCCD_COIL_SEARCH && c <= `PCCD_COIL_START
      && (on || d == `PCCD_DATA_OFF);
    ef = ok && c == `PCCD_COIL_FINISH && on && !m_fin;
    et = ok && c == `PCCD_COIL_START && on && !m_st && !m_fin;
    er = ok && c == `PCCD_COIL_START && on && !m_st && m_fin;
    if (ok && c == `PCCD_COIL_SEARCH) m_ss = on;
    if (ok && c == `PCCD_COIL_FINISH) m_fin = on;
    if (ok && c == `PCCD_COIL_START) m_st = on;
    if (et) m_lp = pnum;
    chk_b("done", 1'b1, st[`PCCD_ST_DONE]);
    chk_b("busy", 1'b0, st[`PCCD_ST_BUSY]);
    chk_b("echo ok", 1'(ok && t != 0), st[`PCCD_ST_OK]);
    chk_b("seen", 1'(ok && t != 0), st[`PCCD_ST_SEEN]);
    chk_w("accepted", 16'(ok), 16'(na - a0));
    chk_b("search", 1'(m_ss), ss);
    chk_b("finish", 1'(m_fin), fin);
    chk_w("finish pulse", 16'(ef), 16'(nf - f0));
    chk_w("start", 16'(et), 16'(nt - t0));
    chk_w("rejected", 16'(er), 16'(nr - r0));
    chk_w("program", 16'(m_lp), lprog);
    chk_w("length", 16'h8, 16'(wq.size()));
  endtask
  // Bench-made frame on the second link, data inverted once released
  task automatic send2(input logic [63:0] f, input int extra);
    logic [63:0] s;
    s = f;
    for (int i = 0; i < 8 + extra; i++) begin
      @(posedge hclk);
      link2.m2s_valid <= 1'b1;
      link2.m2s_data <= s[63:56];
      s = s << 8;
    end
    @(posedge hclk);
    link2.m2s_valid <= 1'b0;
    link2.m2s_data <= ~link2.m2s_data;
    repeat (600) @(posedge hclk);
  endtask
  // Check bytes of a six-byte message, in wire order
  function automatic logic [15:0] crc_of(input logic [47:0] m);
    logic [15:0] c;
    c = `PCCD_CRC_INIT;
    for (int i = 5; i >= 0; i--) begin
      c ^= {8'h00, m[i*8 +: 8]};
      for (int j = 0; j < 8; j++) begin
        c = c[0] ? ((c >> 1) ^ `PCCD_CRC_POLY) : (c >> 1);
      end
    end
    return {c[7:0], c[15:8]};
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #300000;
    fail_count++;
    results();
  end
  initial begin
    logic [31:0] st;
    logic [7:0] t;
    logic [15:0] c, d;
    int a0;
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    axis_id = 4'h0;
    pnum = 16'h0;
    link2.m2s_valid = 1'b0;
    link2.m2s_data = 8'h00;
    void'($urandom(32'hCA58));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    ahb(1'b0, 8'h14, 32'h0, st);
    chk_w("unmapped", 16'h0, st[15:0]);
    chk_b("okay", 1'b0, hresp);
    foreach (DIR[i]) begin
      query(8'h01, DIR[i][47:32], DIR[i][31:16]);
      chk_w("coil", DIR[i][47:32], {wq[2], wq[3]});
      chk_w("crc", DIR[i][15:0], {wq[6], wq[7]});
    end
    $display("test directed done");
    axis_id <= 4'($urandom);
    @(posedge hclk);
    for (int i = 0; i < 30; i++) begin
      case ($urandom % 4)
        0: t = {4'h0, axis_id} + 8'h01;
        1: t = 8'h00;
        2: t = {4'h0, axis_id} + 8'h02;
        default: t = 8'($urandom);
      endcase
      c = 16'h049C + 16'($urandom % 4);
      d = ($urandom % 2) ? `PCCD_DATA_ON : `PCCD_DATA_OFF;
      if ($urandom % 4 == 0) d = 16'($urandom);
      query(t, c, d);
    end
    $display("test random done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk_b("reset search", 1'b0, ss);
    chk_b("reset finish", 1'b0, fin);
    m_ss = 0;
    m_fin = 0;
    m_st = 0;
    m_lp = 0;
    query({4'h0, axis_id} + 8'h01, `PCCD_COIL_START, `PCCD_DATA_ON);
    $display("test reset done");
    a0 = na2;
    send2(64'h0105_049E_FF00_ECE5, 0);
    chk_b("bad crc", 1'b0, 1'(na2 > a0));
    chk_w("crc model", 16'h1CE4, crc_of(48'h0105_049D_FF00));
    send2({48'h0106_049D_FF00, crc_of(48'h0106_049D_FF00)}, 0);
    chk_b("bad function", 1'b0, 1'(na2 > a0));
    send2(64'h0105_049D_FF00_1CE4, 1);
    chk_b("long frame", 1'b0, 1'(na2 > a0));
    chk_b("no echo", 1'b0, 1'(ns2 > 0));
    send2(64'h0105_049E_FF00_ECE4, 0);
    chk_b("good crc", 1'b1, fin2);
    $display("test bad frame done");
    results();
  end
endmodule
`default_nettype wire
